// ---- core/hwm_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the scan sequencer.
`ifndef HWM_DEFINES_SVH
`define HWM_DEFINES_SVH

// Register offsets.
`define HWM_ADDR_SCAN_CONTROL 8'h00
`define HWM_ADDR_FAN_DAC 8'h04
`define HWM_ADDR_FAN_PWM 8'h05
`define HWM_ADDR_ALARM0 8'h18
`define HWM_ADDR_ALARM1 8'h19
`define HWM_ADDR_ALARM2 8'h1A
`define HWM_ADDR_SHARED_LOW 8'h27
`define HWM_ADDR_SHARED_HIGH 8'h29
`define HWM_ADDR_VALUE_BASE 8'h40
`define HWM_ADDR_HIGH_BASE 8'h60
`define HWM_ADDR_LOW_BASE 8'h80

// Scan control fields.
`define HWM_CTL_START 0
`define HWM_CTL_INT_EN 1
`define HWM_CTL_INT_CLR 2
`define HWM_CTL_SHARED_ANALOG 3

// Reset values.
`define HWM_RST_FAN_DAC 8'hFF
`define HWM_RST_FAN_PWM 8'h00
`define HWM_RST_HIGH 8'hFF
`define HWM_RST_LOW 8'h00

// Channel order within one pass.
`define HWM_NUM_CHAN 20
`define HWM_CH_REMOTE1 5'h00
`define HWM_CH_SHARED_A 5'h0A
`define HWM_CH_SHARED_B 5'h0B
`define HWM_CH_REMOTE2 5'h12
`define HWM_CH_LOCAL 5'h13
`define HWM_CH_LAST 5'h13
`define HWM_SAMPLES 16

// Timing.
`define HWM_CLK_PERIOD_NS 10
`define HWM_OSC_PERIOD_NS 44444
`define HWM_OSC_CYCLES (`HWM_OSC_PERIOD_NS / `HWM_CLK_PERIOD_NS)
`define HWM_CONV_VOLT_NS 711000
`define HWM_CONV_REMOTE_NS 2130000
`define HWM_CONV_VOLT_TICKS ((`HWM_CONV_VOLT_NS + `HWM_OSC_PERIOD_NS - 1) / `HWM_OSC_PERIOD_NS)
`define HWM_CONV_REMOTE_TICKS ((`HWM_CONV_REMOTE_NS + `HWM_OSC_PERIOD_NS - 1) / `HWM_OSC_PERIOD_NS)
`define HWM_PWM_PERIOD_NS 13333333
`define HWM_PWM_STEP_CYCLES (`HWM_PWM_PERIOD_NS / `HWM_CLK_PERIOD_NS / 256)

`endif

// ---- core/hwm_pkg.sv ----
// Types shared by the scan sequencer and its bench.
package hwm_pkg;

	// Sequencer states, one-hot.
	typedef enum logic [2:0] {
		HWM_ST_IDLE = 3'b001,
		HWM_ST_SAMPLE = 3'b010,
		HWM_ST_STORE = 3'b100
	} hwm_state_type;

	// Software register request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} hwm_reg_req_type;

	// Request to the converter front end.
	typedef struct packed {
		logic [4:0] chan;
		logic remote;
		logic sample;
	} hwm_adc_req_type;

	// Demands from the automatic fan controller.
	typedef struct packed {
		logic dac_en;
		logic pwm_en;
		logic [7:0] dac_demand;
		logic [7:0] pwm_demand;
	} hwm_fan_auto_type;

endpackage

// ---- core/hwm_scan_seq.sv ----
// Round-robin measurement sequencer with limit alarms and fan drive registers.
// Summary of operation
// - Temperature results are 8-bit twos complement whole degrees, 80h to 7Fh.
// - Voltage channels hold high and low limits; out-of-range raises a request.
// - Temperature channels hold a high limit and a low limit; out-of-range raises a request.
// - Writing start one with interrupt-clear zero begins the scan.
// - The interrupt output is driven only while interrupt enable is one.
// - Channels convert in fixed order, remote one first, local temperature last.
// - Each result is written to its value register when it completes, except the shared-pin kind not selected.
// - The scan repeats until software writes start zero or interrupt clear one.
// - Conversions take 711 us, or 2.13 ms on remote channels.
// - Each channel is sampled 16 times and the average is stored, except the shared-pin kind not selected.
// - The shared pins are measured every pass as voltages and as a diode.
// - Analog mode stores 27h and 29h; diode mode stores temperature at 29h only.
// - Scan timing comes from a 22.5 kHz tick, a pass of about 273 ms.
// - Fan speed measurement runs independently of this scan sequencer.
// - An unsigned 8-bit DAC code comes from the register at 04h.
// - Reset loads FFh into the DAC register for full fan speed.
// - Under automatic control the DAC upper nibble is the minimum drive.
// - A PWM output near 75 Hz takes its duty from register 05h.
// - Under automatic control the PWM upper nibble is the minimum drive, or the DAC nibble when both outputs are automatic.
// - Scan control bit 3 zero selects diode, one selects two analog inputs.
`timescale 1ns/1ps
`include "hwm_defines.svh"

module hwm_scan_seq
	import hwm_pkg::*;
#(
	parameter int OSC_CYCLES = `HWM_OSC_CYCLES,
	parameter int PWM_STEP_CYCLES = `HWM_PWM_STEP_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire hwm_reg_req_type i_reg,
	output logic [7:0] o_rdata,
	output hwm_adc_req_type o_adc,
	input wire logic [7:0] i_adc_data,
	input wire hwm_fan_auto_type i_auto,
	output logic [7:0] o_dac_code,
	output logic o_pwm,
	output logic o_int
);

	// Counter widths follow the divider settings, so a short divider needs few bits.
	localparam int unsigned OSC_W = $clog2(OSC_CYCLES + 1);
	localparam int unsigned PWM_W = $clog2(PWM_STEP_CYCLES + 1);

	// Sequencer, control and register storage.
	hwm_state_type state_q;
	logic [3:0] ctl_q;
	logic [7:0] dac_q;
	logic [7:0] pwm_q;
	logic [7:0] val_q [`HWM_NUM_CHAN];
	logic [7:0] high_q [`HWM_NUM_CHAN];
	logic [7:0] low_q [`HWM_NUM_CHAN];
	logic [`HWM_NUM_CHAN-1:0] alarm_q;
	logic [`HWM_NUM_CHAN-1:0] alarm_set;

	// Scan position and conversion timing.
	logic [4:0] chan_q;
	logic [3:0] samp_q;
	logic [5:0] tick_cnt_q;
	logic [OSC_W-1:0] osc_q;
	logic tick;

	// Averaging and store decisions.
	logic [11:0] acc_q;
	logic [11:0] acc_d;
	logic [7:0] avg;
	logic is_remote;
	logic is_temp;
	logic store_ok;
	logic conv_done;
	logic ctl_wr;
	logic [7:0] rdata_d;

	// Fan drive.
	logic [PWM_W-1:0] pwm_pre_q;
	logic [7:0] pwm_phase_q;
	logic [7:0] dac_floor;
	logic [7:0] pwm_floor;
	logic [7:0] pwm_eff;

	// Every write to offset zero reaches the scan control register.
	assign ctl_wr = i_reg.wr && (i_reg.addr == `HWM_ADDR_SCAN_CONTROL);

	// Channel class; remote diodes take the long conversion.
	assign is_remote = (chan_q == `HWM_CH_REMOTE1) || (chan_q == `HWM_CH_REMOTE2);
	assign is_temp = is_remote || (chan_q == `HWM_CH_LOCAL);

	// Free-running 22.5 kHz tick derived from the system clock.
	// A fixed divider gives the nominal rate; the tolerance that stretches a pass towards
	// 290 ms belongs to the analog oscillator and is not modelled here.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			osc_q <= '0;
		end else if (osc_q == OSC_W'(OSC_CYCLES - 1)) begin
			osc_q <= '0;
		end else begin
			osc_q <= osc_q + 1'b1;
		end
	end
	// The tick is the divider's terminal count, one clock wide.
	assign tick = (osc_q == OSC_W'(OSC_CYCLES - 1));

	// A sample ends after 16 ticks, or 48 ticks on a remote diode.
	// The strobe is gated by the start bit, so a stop write silences the converter at the
	// very next edge instead of letting one more sample slip out while the state unwinds.
	assign conv_done = tick && ctl_q[`HWM_CTL_START] && (state_q == HWM_ST_SAMPLE) &&
		(tick_cnt_q == (is_remote ? 6'(`HWM_CONV_REMOTE_TICKS - 1) :
		6'(`HWM_CONV_VOLT_TICKS - 1)));

	// Scan control register; start only counts when clear is written zero.
	// Interrupt clear is a strobe: it never stays set, so the bit always reads back zero.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl_q <= 4'h0;
		end else if (ctl_wr) begin
			ctl_q[`HWM_CTL_START] <= i_reg.wdata[`HWM_CTL_START] &
				~i_reg.wdata[`HWM_CTL_INT_CLR];
			ctl_q[`HWM_CTL_INT_EN] <= i_reg.wdata[`HWM_CTL_INT_EN];
			ctl_q[`HWM_CTL_INT_CLR] <= 1'b0;
			ctl_q[`HWM_CTL_SHARED_ANALOG] <= i_reg.wdata[`HWM_CTL_SHARED_ANALOG];
		end
	end

	// Sequencer; a stop abandons the pass so a restart begins at channel zero.
	// IDLE waits one cycle after start, SAMPLE counts ticks and samples, and STORE writes
	// the average and steps to the next channel.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= HWM_ST_IDLE;
			chan_q <= `HWM_CH_REMOTE1;
			samp_q <= 4'h0;
			tick_cnt_q <= 6'h00;
		end else if (!ctl_q[`HWM_CTL_START]) begin
			state_q <= HWM_ST_IDLE;
			chan_q <= `HWM_CH_REMOTE1;
			samp_q <= 4'h0;
			tick_cnt_q <= 6'h00;
		end else begin
			unique case (state_q)
				HWM_ST_IDLE: begin
					state_q <= HWM_ST_SAMPLE;
				end
				HWM_ST_SAMPLE: begin
					if (conv_done) begin
						tick_cnt_q <= 6'h00;
						samp_q <= samp_q + 1'b1;
						if (samp_q == 4'(`HWM_SAMPLES - 1)) begin
							state_q <= HWM_ST_STORE;
						end
					end else if (tick) begin
						tick_cnt_q <= tick_cnt_q + 1'b1;
					end
				end
				HWM_ST_STORE: begin
					// The last channel wraps to the first, which keeps the scan continuous.
					state_q <= HWM_ST_SAMPLE;
					if (chan_q == `HWM_CH_LAST) begin
						chan_q <= `HWM_CH_REMOTE1;
					end else begin
						chan_q <= chan_q + 1'b1;
					end
				end
			endcase
		end
	end

	// Sum of the 16 samples; temperatures sign-extend so the mean stays signed.
	// Twelve bits hold sixteen full-scale codes, 16 x 255 = 4080, with no overflow.
	always_comb begin
		acc_d = acc_q;
		if (state_q != HWM_ST_SAMPLE) begin
			acc_d = 12'h000;
		end else if (conv_done) begin
			acc_d = acc_q + (is_temp ? {{4{i_adc_data[7]}}, i_adc_data} :
				{4'h0, i_adc_data});
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			acc_q <= 12'h000;
		end else begin
			acc_q <= acc_d;
		end
	end

	// Dividing by 16 keeps the top byte, which stays twos complement for temperatures.
	// Truncation rounds toward minus infinity, the same way for both signs.
	assign avg = acc_q[11:4];

	// Shared pins yield both readings every pass; only the selected kind is kept.
	// In diode mode the shared-input value registers keep whatever they last held, so
	// software must treat them as invalid until analog mode is selected again.
	always_comb begin
		store_ok = 1'b1;
		if (chan_q == `HWM_CH_REMOTE2) begin
			store_ok = ~ctl_q[`HWM_CTL_SHARED_ANALOG];
		end else if ((chan_q == `HWM_CH_SHARED_A) || (chan_q == `HWM_CH_SHARED_B)) begin
			store_ok = ctl_q[`HWM_CTL_SHARED_ANALOG];
		end
	end

	// Result and limit registers; values only change on a completed channel.
	// Limits come up wide open for voltages. Read signed, a high limit of FFh is minus one
	// degree, so temperature channels alarm until software programs real limits.
	// Limit writes take effect whether or not the scan is running.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < `HWM_NUM_CHAN; i++) begin
				val_q[i] <= 8'h00;
				high_q[i] <= `HWM_RST_HIGH;
				low_q[i] <= `HWM_RST_LOW;
			end
		end else begin
			if ((state_q == HWM_ST_STORE) && store_ok) begin
				val_q[chan_q] <= avg;
			end
			for (int i = 0; i < `HWM_NUM_CHAN; i++) begin
				if (i_reg.wr && (i_reg.addr == (`HWM_ADDR_HIGH_BASE + 8'(i)))) begin
					high_q[i] <= i_reg.wdata;
				end
				if (i_reg.wr && (i_reg.addr == (`HWM_ADDR_LOW_BASE + 8'(i)))) begin
					low_q[i] <= i_reg.wdata;
				end
			end
		end
	end

	// Limit check on the fresh average; temperatures compare signed.
	always_comb begin
		alarm_set = '0;
		if ((state_q == HWM_ST_STORE) && store_ok) begin
			if (is_temp) begin
				alarm_set[chan_q] = ($signed(avg) > $signed(high_q[chan_q])) ||
					($signed(avg) < $signed(low_q[chan_q]));
			end else begin
				alarm_set[chan_q] = (avg > high_q[chan_q]) ||
					(avg < low_q[chan_q]);
			end
		end
	end

	// Sticky alarms; a new alarm in the clearing cycle survives the clear.
	// One bit per channel, read back through three alarm registers.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			alarm_q <= '0;
		end else if (ctl_wr && i_reg.wdata[`HWM_CTL_INT_CLR]) begin
			alarm_q <= alarm_set;
		end else begin
			alarm_q <= alarm_q | alarm_set;
		end
	end

	// Interrupt request is gated by the enable bit.
	// Registered, so the pin cannot glitch while alarms and the enable change together.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_int <= 1'b0;
		end else begin
			o_int <= ctl_q[`HWM_CTL_INT_EN] && (|alarm_q);
		end
	end

	// Fan drive registers; the DAC comes up at full scale. This logic shares nothing
	// with the scan, so fan speed measurement elsewhere keeps its own loop.
	// Nothing here waits on the sequencer state, so fan writes never stall a pass.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dac_q <= `HWM_RST_FAN_DAC;
			pwm_q <= `HWM_RST_FAN_PWM;
		end else if (i_reg.wr) begin
			if (i_reg.addr == `HWM_ADDR_FAN_DAC) begin
				dac_q <= i_reg.wdata;
			end
			if (i_reg.addr == `HWM_ADDR_FAN_PWM) begin
				pwm_q <= i_reg.wdata;
			end
		end
	end

	// The floor is the nibble times sixteen, so the low nibble of either register is ignored.
	// Automatic control may only raise the drive above the programmed floor. When both
	// outputs are automatic, the DAC nibble sets the PWM floor too.
	assign dac_floor = {dac_q[7:4], 4'h0};
	assign pwm_floor = (i_auto.dac_en && i_auto.pwm_en) ? dac_floor :
		{pwm_q[7:4], 4'h0};
	assign pwm_eff = !i_auto.pwm_en ? pwm_q :
		((i_auto.pwm_demand > pwm_floor) ? i_auto.pwm_demand : pwm_floor);

	// DAC code: the register in manual mode, the larger of demand and floor otherwise.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_dac_code <= `HWM_RST_FAN_DAC;
		end else if (!i_auto.dac_en) begin
			o_dac_code <= dac_q;
		end else begin
			o_dac_code <= (i_auto.dac_demand > dac_floor) ? i_auto.dac_demand :
				dac_floor;
		end
	end

	// PWM: 256 steps per period of about 13.3 ms, so near 75 Hz; FFh leaves one low step.
	// A duty change applies from the next clock, so one period may carry a mixed pulse.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pwm_pre_q <= '0;
			pwm_phase_q <= 8'h00;
			o_pwm <= 1'b0;
		end else begin
			if (pwm_pre_q == PWM_W'(PWM_STEP_CYCLES - 1)) begin
				pwm_pre_q <= '0;
				pwm_phase_q <= pwm_phase_q + 1'b1;
			end else begin
				pwm_pre_q <= pwm_pre_q + 1'b1;
			end
			o_pwm <= (pwm_phase_q < pwm_eff);
		end
	end

	// Converter request: channel, diode mode and the end-of-sample strobe. One assignment
	// drives the whole struct, so no member has a second driver.
	assign o_adc = '{
		chan: chan_q,
		remote: is_remote,
		sample: conv_done
	};

	// Read decode; unmapped addresses return zero.
	// Values and limits share one loop so the map stays in step with the channel count.
	always_comb begin
		rdata_d = 8'h00;
		unique case (i_reg.addr)
			`HWM_ADDR_SCAN_CONTROL: rdata_d = {4'h0, ctl_q};
			`HWM_ADDR_FAN_DAC: rdata_d = dac_q;
			`HWM_ADDR_FAN_PWM: rdata_d = pwm_q;
			`HWM_ADDR_ALARM0: rdata_d = alarm_q[7:0];
			`HWM_ADDR_ALARM1: rdata_d = alarm_q[15:8];
			`HWM_ADDR_ALARM2: rdata_d = {4'h0, alarm_q[19:16]};
			`HWM_ADDR_SHARED_LOW: rdata_d = val_q[`HWM_CH_SHARED_A];
			`HWM_ADDR_SHARED_HIGH: begin
				rdata_d = ctl_q[`HWM_CTL_SHARED_ANALOG] ? val_q[`HWM_CH_SHARED_B] :
					val_q[`HWM_CH_REMOTE2];
			end
			default: begin
				for (int i = 0; i < `HWM_NUM_CHAN; i++) begin
					if (i_reg.addr == (`HWM_ADDR_VALUE_BASE + 8'(i))) begin
						rdata_d = val_q[i];
					end
					if (i_reg.addr == (`HWM_ADDR_HIGH_BASE + 8'(i))) begin
						rdata_d = high_q[i];
					end
					if (i_reg.addr == (`HWM_ADDR_LOW_BASE + 8'(i))) begin
						rdata_d = low_q[i];
					end
				end
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe.
	// Returning zero between reads keeps a stale value from passing for a fresh answer.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 8'h00;
		end else if (i_reg.rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= 8'h00;
		end
	end

endmodule // hwm_scan_seq

// ---- tb/hwm_adc_model.sv ----
// Converter front end model: fixed level per channel with an alternating ripple.
`timescale 1ns/1ps
module hwm_adc_model
	import hwm_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire hwm_adc_req_type i_adc,
	output logic [7:0] o_data
);
	logic flip_q;
	logic [7:0] level;

	// Ripple flips each sample, so only a true 16-sample average lands on the level.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flip_q <= 1'b0;
		end else if (i_adc.sample) begin
			flip_q <= ~flip_q;
		end
	end

	// Diode and local channels read twos complement temperatures, the rest voltages.
	always_comb begin
		case (i_adc.chan)
			5'h00: level = 8'hE7;
			5'h12: level = 8'h7D;
			5'h13: level = 8'h9C;
			default: level = {i_adc.chan, 3'h3};
		endcase
	end

	// Away from the capture edge the line shows the inverse, so a late capture is caught.
	assign o_data = i_adc.sample ? (flip_q ? level - 8'h01 : level + 8'h01) : ~level;
endmodule // hwm_adc_model

// ---- tb/hwm_scan_seq_bench.sv ----
// Self-checking bench for the scan sequencer.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", n, e, g); end end
module hwm_scan_seq_bench import hwm_pkg::*;;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	hwm_reg_req_type req = '0;
	hwm_fan_auto_type auto_in = '0;
	hwm_adc_req_type adc;
	logic [7:0] rdata, dac, adc_data, exp_dac;
	logic pwm, irq, rd_d = 1'b0;
	int n_errors = 0, checks = 0, hi;
	integer seed = 32'h77754aab;
	logic [7:0] expq[$];

	always #5 i_clk = ~i_clk;

	hwm_scan_seq #(.OSC_CYCLES(4), .PWM_STEP_CYCLES(2)) dut (.i_clk, .i_reset_n, .i_reg(req),
		.o_rdata(rdata), .o_adc(adc), .i_adc_data(adc_data), .i_auto(auto_in),
		.o_dac_code(dac), .o_pwm(pwm), .o_int(irq));
	hwm_adc_model adc_m (.i_clk, .i_reset_n, .i_adc(adc), .o_data(adc_data));

	// Read data stands only in the cycle after the strobe, so it is taken at that edge.
	always @(posedge i_clk) begin
		rd_d <= req.rd;
		if (rd_d) begin
			`CHK("rdata", expq[0], rdata)
			void'(expq.pop_front());
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		req <= '0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		req <= '0;
		@(posedge i_clk);
	endtask

	// Bounded wait for a channel; a pass takes some 25000 cycles here.
	task automatic wait_chan(input logic [4:0] c);
		int n;
		n = 0;
		while (adc.chan !== c && n < 40000) begin
			@(negedge i_clk);
			n++;
		end
		`CHK("chan", c, adc.chan)
		@(posedge i_clk);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		rd(8'h04, 8'hFF);
		rd(8'h61, 8'hFF);
		wr(8'h04, 8'h5A);
		repeat (2) @(negedge i_clk);
		`CHK("dac", 8'h5A, dac)
		// Auto demand below the floor must be lifted to the upper nibble of the level.
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clk);
			auto_in <= '{1'b1, 1'b0, 8'($random(seed)), 8'h00};
			repeat (3) @(negedge i_clk);
			exp_dac = (auto_in.dac_demand > 8'h50) ? auto_in.dac_demand : 8'h50;
			`CHK("dac_auto", exp_dac, dac)
		end
		@(posedge i_clk);
		auto_in <= '0;
		wr(8'h05, 8'h80);
		hi = 0;
		repeat (512) begin
			@(posedge i_clk);
			hi += pwm;
		end
		`CHK("pwm_high", 256, hi)
		// Both outputs automatic: the DAC nibble, 50h, is the PWM floor, 80 of 256 steps.
		auto_in <= '{1'b1, 1'b1, 8'h00, 8'h20};
		repeat (2) @(posedge i_clk);
		hi = 0;
		repeat (512) begin
			@(posedge i_clk);
			hi += pwm;
		end
		`CHK("pwm_auto", 160, hi)
		auto_in <= '0;
		$display("fan test done");
		wr(8'h61, 8'h0A);
		wr(8'h00, 8'h0B);
		wait_chan(5'h13);
		wait_chan(5'h00);
		rd(8'h40, 8'hE7);
		rd(8'h53, 8'h9C);
		rd(8'h27, 8'h53);
		rd(8'h29, 8'h5B);
		rd(8'h18, 8'h03);
		`CHK("int", 1'b1, irq)
		wr(8'h00, 8'h09);
		repeat (3) @(negedge i_clk);
		`CHK("int_off", 1'b0, irq)
		// Stop in mid-pass, away from channel zero, so the rewind is really exercised.
		wait_chan(5'h05);
		wr(8'h00, 8'h04);
		repeat (300) @(posedge i_clk);
		`CHK("stop_chan", 5'h00, adc.chan)
		rd(8'h41, 8'h0B);
		rd(8'h18, 8'h00);
		$display("analog pass test done");
		wr(8'h00, 8'h01);
		`CHK("restart", 5'h00, adc.chan)
		wait_chan(5'h13);
		wait_chan(5'h00);
		rd(8'h29, 8'h7D);
		rd(8'h27, 8'h53);
		rd(8'h1A, 8'h0C);
		`CHK("int_masked", 1'b0, irq)
		$display("diode pass test done");
		repeat (2) @(posedge i_clk);
		conclude();
	end

	// Two passes, a part pass and the fan tests need some 60000 cycles.
	initial begin
		#1000000;
		n_errors++;
		conclude();
	end
endmodule // hwm_scan_seq_bench

// ---- tb/hwm_scan_seq_chk.sv ----
// Concurrent checks on the ports of the scan sequencer.
`timescale 1ns/1ps
module hwm_scan_seq_chk
	import hwm_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire hwm_reg_req_type i_reg,
	input wire logic [7:0] o_rdata,
	input wire hwm_adc_req_type o_adc,
	input wire logic [7:0] i_adc_data,
	input wire hwm_fan_auto_type i_auto,
	input wire logic [7:0] o_dac_code,
	input wire logic o_pwm,
	input wire logic o_int
);
	logic int_en_q;
	logic [7:0] dac_q;
	wire ctl_wr = i_reg.wr && i_reg.addr == 8'h00;

	// Shadow of the interrupt enable, so the output can be tied to what software wrote.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			int_en_q <= 1'b0;
		end else if (ctl_wr) begin
			int_en_q <= i_reg.wdata[1];
		end
	end

	// Shadow of the DAC level; it must come up at full drive.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dac_q <= 8'hFF;
		end else if (i_reg.wr && i_reg.addr == 8'h04) begin
			dac_q <= i_reg.wdata;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	a_rdata_idle: assert property (!$past(i_reg.rd) |-> o_rdata == 8'h00)
		else $error("read data not idle");
	a_int_gated: assert property (!int_en_q |=> !o_int)
		else $error("interrupt while disabled");
	a_dac_manual: assert property ((!i_auto.dac_en && $stable(dac_q)) [*3] |->
		o_dac_code == dac_q)
		else $error("dac code differs from level");
	a_chan_step: assert property ($changed(o_adc.chan) |->
		o_adc.chan == $past(o_adc.chan) + 5'h01 || o_adc.chan == 5'h00)
		else $error("channel order broken");
	a_chan_range: assert property (o_adc.chan <= 5'h13)
		else $error("channel out of range");
	a_remote_map: assert property (o_adc.remote ==
		(o_adc.chan == 5'h00 || o_adc.chan == 5'h12))
		else $error("remote flag wrong");
	a_sample_gap: assert property (o_adc.sample |=> !o_adc.sample [*8])
		else $error("samples too close");
	a_stop_quiet: assert property (ctl_wr && !i_reg.wdata[0] |=> !o_adc.sample [*8])
		else $error("sampling after stop");
	a_stop_chan: assert property (ctl_wr && (!i_reg.wdata[0] || i_reg.wdata[2]) |=>
		##1 o_adc.chan == 5'h00)
		else $error("stop did not rewind the channel");
endmodule // hwm_scan_seq_chk

bind hwm_scan_seq hwm_scan_seq_chk chk (.i_clk, .i_reset_n, .i_reg, .o_rdata, .o_adc, .i_adc_data,
	.i_auto, .o_dac_code, .o_pwm, .o_int);
